// ===== src/liu_cfg_pkg.sv
// Purpose: constants and types for the line interface config bank
// Assumes: byte-wide host control port, one 200 MHz clock
// Notes:
// How it works
// (R01) Writing one to trigger bit launches one indirect template access.
// (R02) Direction bit zero writes the template, one reads it.
// (R03) Two-bit interval address picks one of four unit intervals.
// (R04) Four-bit sample address picks one of sixteen samples.
// (R05) Triggered write stores the seven-bit amplitude into the sample.
// (R06) Triggered read returns the stored amplitude into the data register.
// (R07) Power-down bit set powers the receive path down.
// (R08) Invert bit makes the receive data outputs active low.
// (R09) Edge select picks rising or falling recovered clock for updates.
// (R10) Edge select is ignored in slicer mode.
// (R11) Mode 00 outputs line-decoded single-rail data.
// (R12) Mode 01 outputs AMI-decoded single-rail data.
// (R13) Mode 10 outputs retimed dual-rail data, decoder bypassed.
// (R14) Mode 11 outputs raw slicer return-to-zero dual-rail data.
// (R15) Equalizer bit switches equalizer; LOS thresholds apply only when on.
// (R16) Five-bit LOS code, reset 10101, 2 dB steps; codes above 01010 reserved.
// (R17) Template shapes transmit pulses only for select code 11XX.
// (R18) Six-bit scaling factor multiplies user amplitude, reset 100001.
// (R19) Host sets addresses and data before triggering, holds them during.
package liu_cfg_pkg;
	localparam logic [7:0] ACCESS_CTRL_OFS = 8'h08;
	localparam logic [7:0] PULSE_DATA_OFS  = 8'h09;
	localparam logic [7:0] RX_CTRL_OFS     = 8'h0A;
	localparam logic [7:0] RX_EQ_LOS_OFS   = 8'h0B;
	localparam int TRIGGER_BIT   = 7;
	localparam int DIR_BIT       = 6;
	localparam int UI_LSB        = 4;
	localparam int RX_OFF_BIT    = 4;
	localparam int RX_INV_BIT    = 3;
	localparam int RX_EDGE_BIT   = 2;
	localparam int EQUALIZER_ENABLE_BIT     = 6;
	localparam logic [4:0] LOS_RESET     = 5'h15;
	localparam logic [4:0] LOS_LAST_CODE = 5'h0A;
	localparam logic [4:0] DB_STEP       = 5'h02;
	localparam logic [5:0] DECLARE_GAP   = 6'h04;
	localparam logic [1:0] TEMPLATE_USER = 2'h3;
	localparam logic [5:0] SCALE_RESET   = 6'h21;
	localparam logic [1:0] MODE_LINE     = 2'h0;
	localparam logic [1:0] MODE_AMI      = 2'h1;
	localparam logic [1:0] MODE_RETIMED  = 2'h2;
	localparam logic [1:0] MODE_SLICER   = 2'h3;

	typedef struct packed {
		logic       power_down;
		logic       rx_data_invert;
		logic       clk_falling;
		logic [1:0] rx_decode_mode;
	} rx_cfg_t;

	typedef struct packed {
		logic       dir_read;
		logic [1:0] interval_addr;
		logic [3:0] sample_addr;
	} ram_access_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} access_state_t;
endpackage

// ===== src/liu_pulse_ram_rx_config.sv
// Purpose: host register bank, pulse template RAM, receive path select
// Assumes: all inputs synchronous to ref_clk_i; rx_clk_i is sampled
// Notes: host read data appears one cycle after rd_i with rd_ack_o
`timescale 1ns/100ps
module liu_pulse_ram_rx_config
	import liu_cfg_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o,
	output logic             rd_ack_o,
	input  wire logic [3:0]  tx_template_select_i,
	input  wire logic [5:0]  amplitude_scaling_i,
	input  wire logic [1:0]  tx_interval_i,
	input  wire logic [3:0]  tx_sample_i,
	output logic             tx_user_active_o,
	output logic      [12:0] tx_scaled_amp_o,
	input  wire logic        rx_clk_i,
	input  wire logic        rx_line_data_i,
	input  wire logic        rx_ami_data_i,
	input  wire logic        rx_retimed_pos_i,
	input  wire logic        rx_retimed_neg_i,
	input  wire logic        rx_slicer_pos_i,
	input  wire logic        rx_slicer_neg_i,
	output logic             rx_data_o,
	output logic             rx_positive_rail_out_o,
	output logic             rx_negative_rail_out_o,
	output logic             rx_power_down_o,
	output logic             equalizer_enable_o,
	output logic             los_program_o,
	output logic      [5:0]  los_clear_db_o,
	output logic      [5:0]  los_declare_db_o,
	output logic             los_reserved_o
);
	logic [6:0]    template_ram [64];
	access_state_t state_reg;
	ram_access_t   access_reg;
	logic [6:0]    amplitude_value_reg;
	rx_cfg_t       rx_cfg_reg;
	logic          equalizer_enable_reg;
	logic [4:0]    signal_loss_level_reg;
	logic          rx_clk_prev_reg;
	logic          rx_update;
	logic          wr_ctrl;
	logic          wr_data;
	logic          launch;
	logic [6:0]    tx_amp;

	function automatic logic [5:0] ram_index(input logic [1:0] ui,
		input logic [3:0] samp);
		ram_index = {ui, samp};
	endfunction

	assign wr_ctrl = wr_i && (addr_i == ACCESS_CTRL_OFS);
	assign wr_data = wr_i && (addr_i == PULSE_DATA_OFS);
	// (R01) trigger on write one
	assign launch = wr_ctrl && wdata_i[TRIGGER_BIT] && (state_reg == ST_IDLE);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			access_reg <= '0;
		end else if (wr_ctrl && (state_reg == ST_IDLE)) begin
			// (R03) interval field
			access_reg.interval_addr <= wdata_i[UI_LSB+1:UI_LSB];
			// (R04) sample field
			access_reg.sample_addr <= wdata_i[3:0];
			// (R02) direction bit
			access_reg.dir_read <= wdata_i[DIR_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (launch) begin
						state_reg <= ST_BUSY;
					end
				end
				ST_BUSY: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// (R05) store amplitude on write access
	always_ff @(posedge ref_clk_i) begin
		if ((state_reg == ST_BUSY) && !access_reg.dir_read) begin
			template_ram[ram_index(access_reg.interval_addr,
				access_reg.sample_addr)] <= amplitude_value_reg;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			amplitude_value_reg <= '0;
		end else if ((state_reg == ST_BUSY) && access_reg.dir_read) begin
			// (R06) read result into data register
			amplitude_value_reg <= template_ram[ram_index(
				access_reg.interval_addr, access_reg.sample_addr)];
		end else if (wr_data && (state_reg == ST_IDLE)) begin
			amplitude_value_reg <= wdata_i[6:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_cfg_reg <= '0;
			equalizer_enable_reg <= 1'b0;
			signal_loss_level_reg <= LOS_RESET;
		end else if (wr_i) begin
			if (addr_i == RX_CTRL_OFS) begin
				rx_cfg_reg <= wdata_i[4:0];
			end
			if (addr_i == RX_EQ_LOS_OFS) begin
				equalizer_enable_reg <= wdata_i[EQUALIZER_ENABLE_BIT];
				signal_loss_level_reg <= wdata_i[4:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
			rd_ack_o <= 1'b0;
		end else begin
			rd_ack_o <= rd_i;
			if (rd_i) begin
				case (addr_i)
					ACCESS_CTRL_OFS: rdata_o <= {state_reg == ST_BUSY,
						access_reg};
					PULSE_DATA_OFS: rdata_o <= {1'b0, amplitude_value_reg};
					RX_CTRL_OFS: rdata_o <= {3'h0, rx_cfg_reg};
					RX_EQ_LOS_OFS: rdata_o <= {1'b0, equalizer_enable_reg,
						1'b0, signal_loss_level_reg};
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// (R17) user template only for 11XX
	assign tx_amp = template_ram[ram_index(tx_interval_i, tx_sample_i)];

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_user_active_o <= 1'b0;
			tx_scaled_amp_o <= '0;
		end else begin
			tx_user_active_o <= (tx_template_select_i[3:2] == TEMPLATE_USER);
			if (tx_template_select_i[3:2] == TEMPLATE_USER) begin
				// (R18) scale user amplitude
				tx_scaled_amp_o <= 13'(tx_amp) * 13'(amplitude_scaling_i);
			end else begin
				tx_scaled_amp_o <= '0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_clk_prev_reg <= 1'b0;
		end else begin
			rx_clk_prev_reg <= rx_clk_i;
		end
	end

	// (R09) edge select, (R10) ignored in slicer mode
	always_comb begin
		if (rx_cfg_reg.rx_decode_mode == MODE_SLICER) begin
			rx_update = 1'b1;
		end else if (rx_cfg_reg.clk_falling) begin
			rx_update = rx_clk_prev_reg && !rx_clk_i;
		end else begin
			rx_update = !rx_clk_prev_reg && rx_clk_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_data_o <= 1'b0;
			rx_positive_rail_out_o <= 1'b0;
			rx_negative_rail_out_o <= 1'b0;
		end else if (rx_cfg_reg.power_down) begin
			// (R07) powered-down path outputs idle level
			rx_data_o <= rx_cfg_reg.rx_data_invert;
			rx_positive_rail_out_o <= rx_cfg_reg.rx_data_invert;
			rx_negative_rail_out_o <= rx_cfg_reg.rx_data_invert;
		end else if (rx_update) begin
			// (R08) polarity applied to every rail
			case (rx_cfg_reg.rx_decode_mode)
				// (R11) line-decoded single rail
				MODE_LINE: begin
					rx_data_o <= rx_line_data_i ^ rx_cfg_reg.rx_data_invert;
					rx_positive_rail_out_o <= rx_cfg_reg.rx_data_invert;
					rx_negative_rail_out_o <= rx_cfg_reg.rx_data_invert;
				end
				// (R12) AMI single rail
				MODE_AMI: begin
					rx_data_o <= rx_ami_data_i ^ rx_cfg_reg.rx_data_invert;
					rx_positive_rail_out_o <= rx_cfg_reg.rx_data_invert;
					rx_negative_rail_out_o <= rx_cfg_reg.rx_data_invert;
				end
				// (R13) retimed dual rail
				MODE_RETIMED: begin
					rx_data_o <= rx_cfg_reg.rx_data_invert;
					rx_positive_rail_out_o <= rx_retimed_pos_i
						^ rx_cfg_reg.rx_data_invert;
					rx_negative_rail_out_o <= rx_retimed_neg_i
						^ rx_cfg_reg.rx_data_invert;
				end
				// (R14) raw slicer dual rail
				default: begin
					rx_data_o <= rx_cfg_reg.rx_data_invert;
					rx_positive_rail_out_o <= rx_slicer_pos_i
						^ rx_cfg_reg.rx_data_invert;
					rx_negative_rail_out_o <= rx_slicer_neg_i
						^ rx_cfg_reg.rx_data_invert;
				end
			endcase
		end
	end

	assign rx_power_down_o = rx_cfg_reg.power_down;
	assign equalizer_enable_o = equalizer_enable_reg;
	// (R15) thresholds gated by equalizer
	assign los_program_o = equalizer_enable_reg && !los_reserved_o;
	// (R16) 2 dB steps, declare 4 dB above clear
	assign los_clear_db_o = 6'(signal_loss_level_reg) * 6'(DB_STEP);
	assign los_declare_db_o = 6'(los_clear_db_o + DECLARE_GAP);
	assign los_reserved_o = signal_loss_level_reg > LOS_LAST_CODE;

	a_trigger_busy: assert property (@(posedge ref_clk_i) // R01
		disable iff (rst_i)
		launch |=> (state_reg == ST_BUSY) ##1 (state_reg == ST_IDLE))
		else $error("trigger did not run one access");

	a_busy_hold: assert property (@(posedge ref_clk_i) // R01
		disable iff (rst_i)
		(state_reg == ST_BUSY) |=> $stable(access_reg))
		else $error("access fields moved while busy");

	a_write_stores: assert property (@(posedge ref_clk_i) // R05
		disable iff (rst_i)
		(state_reg == ST_BUSY && !access_reg.dir_read) |=>
		template_ram[$past(ram_index(access_reg.interval_addr,
		access_reg.sample_addr))] == $past(amplitude_value_reg))
		else $error("write access lost data");

	a_read_returns: assert property (@(posedge ref_clk_i) // R06
		disable iff (rst_i)
		(state_reg == ST_BUSY && access_reg.dir_read) |=>
		amplitude_value_reg == template_ram[ram_index(
		access_reg.interval_addr, access_reg.sample_addr)])
		else $error("read access wrong data");

	a_addr_fields: assert property (@(posedge ref_clk_i) // R03
		disable iff (rst_i)
		launch |=> access_reg == $past(wdata_i[6:0]))
		else $error("access fields not captured");

	a_read_dir: assert property (@(posedge ref_clk_i) // R02
		disable iff (rst_i)
		(state_reg == ST_BUSY && access_reg.dir_read) |=>
		$stable(template_ram[ram_index(access_reg.interval_addr,
		access_reg.sample_addr)]))
		else $error("read access changed template");

	a_power_down: assert property (@(posedge ref_clk_i) // R07
		disable iff (rst_i)
		rx_cfg_reg.power_down |=>
		{rx_data_o, rx_positive_rail_out_o, rx_negative_rail_out_o}
		== {3{$past(rx_cfg_reg.rx_data_invert)}})
		else $error("powered-down path not idle");

	a_line_decode: assert property (@(posedge ref_clk_i) // R11
		disable iff (rst_i)
		(rx_update && !rx_cfg_reg.power_down
		&& rx_cfg_reg.rx_decode_mode == MODE_LINE) |=>
		rx_data_o == $past(rx_line_data_i ^ rx_cfg_reg.rx_data_invert))
		else $error("line-decoded data not passed");

	a_slicer_pass: assert property (@(posedge ref_clk_i) // R14
		disable iff (rst_i)
		(rx_cfg_reg.rx_decode_mode == MODE_SLICER
		&& !rx_cfg_reg.power_down) |=>
		rx_positive_rail_out_o == ($past(rx_slicer_pos_i)
		^ $past(rx_cfg_reg.rx_data_invert)))
		else $error("slicer data not passed");

	a_edge_hold: assert property (@(posedge ref_clk_i) // R09
		disable iff (rst_i)
		(!rx_update && !rx_cfg_reg.power_down) |=> $stable(rx_data_o))
		else $error("receive data moved off edge");

	a_los_gate: assert property (@(posedge ref_clk_i) // R15
		disable iff (rst_i)
		los_program_o |-> equalizer_enable_o
		&& signal_loss_level_reg <= LOS_LAST_CODE)
		else $error("LOS thresholds wrongly enabled");

	a_los_steps: assert property (@(posedge ref_clk_i) // R16
		disable iff (rst_i)
		!los_reserved_o |->
		los_clear_db_o == {signal_loss_level_reg, 1'b0}
		&& los_declare_db_o == los_clear_db_o + DECLARE_GAP)
		else $error("LOS threshold pair wrong");

	a_user_active: assert property (@(posedge ref_clk_i) // R17
		disable iff (rst_i)
		(tx_template_select_i[3:2] == TEMPLATE_USER) |=> tx_user_active_o)
		else $error("user template not flagged");

	a_user_gate: assert property (@(posedge ref_clk_i) // R17
		disable iff (rst_i)
		(tx_template_select_i[3:2] != TEMPLATE_USER) |=>
		tx_scaled_amp_o == 13'h0000 && !tx_user_active_o)
		else $error("template used outside 11XX");
endmodule

// ===== verification/liu_pulse_ram_rx_config_test.sv
// Purpose: self-checking bench for the line interface config bank
// Assumes: one-cycle host strobes, reads answer in one cycle
// Notes: rail sources carry a pattern and its inverse to tell them apart
`timescale 1ns/100ps
module liu_pulse_ram_rx_config_test;
	import liu_cfg_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [7:0]  wdata_i = 8'h00;
	logic [3:0]  tsel = 4'h0;
	logic [1:0]  tui = 2'h0;
	logic [3:0]  tsmp = 4'h0;
	logic [5:0]  scal = SCALE_RESET;
	logic        rx_clk_i = 1'b0;
	logic [5:0]  rx_src = 6'h00;
	logic [7:0]  rdata_o;
	logic        rd_ack_o;
	logic        tx_user_active_o;
	logic [12:0] tx_scaled_amp_o;
	logic        rd_o, rp_o, rn_o, pd_o, eq_o, prog_o, resv_o;
	logic [5:0]  clr_o, dcl_o;
	logic [5:0]  pat = 6'h29;
	logic [5:0]  t_adr [3] = '{6'h00, 6'h3F, 6'h15};
	logic [6:0]  t_dat [3] = '{7'h01, 7'h7F, 7'h2A};
	logic [4:0]  los_c [4] = '{5'h00, 5'h0A, 5'h0B, 5'h1F};
	logic [2:0]  c;
	int          mismatches = 0;
	int          n_checks = 0;
	int          k;

	always #2.5 ref_clk_i = ~ref_clk_i;

	liu_pulse_ram_rx_config u_liu_pulse_ram_rx_config (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
		.rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
		.rd_ack_o(rd_ack_o), .tx_template_select_i(tsel),
		.amplitude_scaling_i(scal), .tx_interval_i(tui),
		.tx_sample_i(tsmp), .tx_user_active_o(tx_user_active_o),
		.tx_scaled_amp_o(tx_scaled_amp_o), .rx_clk_i(rx_clk_i),
		.rx_line_data_i(rx_src[5]), .rx_ami_data_i(rx_src[4]),
		.rx_retimed_pos_i(rx_src[3]), .rx_retimed_neg_i(rx_src[2]),
		.rx_slicer_pos_i(rx_src[1]), .rx_slicer_neg_i(rx_src[0]),
		.rx_data_o(rd_o), .rx_positive_rail_out_o(rp_o),
		.rx_negative_rail_out_o(rn_o), .rx_power_down_o(pd_o),
		.equalizer_enable_o(eq_o), .los_program_o(prog_o),
		.los_clear_db_o(clr_o), .los_declare_db_o(dcl_o),
		.los_reserved_o(resv_o));

	task automatic finish_test();
		if (mismatches == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		int i;
		i = 0;
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		while (rd_ack_o !== 1'b1) begin
			if (i == 4) begin
				mismatches++;
				finish_test();
			end
			i++;
			@(posedge ref_clk_i);
			#1;
		end
		check_value(16'(rdata_o), 16'(exp));
	endtask

	// Receive clock level change, then time for the update to land
	task automatic rx_tick(input logic v, input int n);
		@(posedge ref_clk_i);
		rx_clk_i <= v;
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	function automatic logic [2:0] rx_exp(input logic [2:0] cf,
			input logic [5:0] s);
		logic [2:0] r;
		case (cf[1:0])
			2'd0: r = {s[5], 2'b00};
			2'd1: r = {s[4], 2'b00};
			2'd2: r = {1'b0, s[3], s[2]};
			default: r = {1'b0, s[1], s[0]};
		endcase
		return r ^ {3{cf[2]}};
	endfunction

	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		reg_read(ACCESS_CTRL_OFS, 8'h00);
		reg_read(PULSE_DATA_OFS, 8'h00);
		reg_read(RX_CTRL_OFS, 8'h00);
		reg_read(RX_EQ_LOS_OFS, 8'h15);
		check_value(16'(clr_o), 16'h002A);
		reg_write(8'h0C, 8'hFF);
		reg_read(8'h0C, 8'h00);
		for (k = 0; k < 3; k++) begin
			reg_write(PULSE_DATA_OFS, {1'b0, t_dat[k]});
			reg_write(ACCESS_CTRL_OFS, {2'b10, t_adr[k]});
		end
		for (k = 0; k < 3; k++) begin
			reg_write(PULSE_DATA_OFS, 8'h00);
			reg_write(ACCESS_CTRL_OFS, {2'b11, t_adr[k]});
			reg_read(PULSE_DATA_OFS, {1'b0, t_dat[k]});
			reg_read(ACCESS_CTRL_OFS, {2'b01, t_adr[k]});
			@(posedge ref_clk_i);
			tsel <= 4'(12 + k);
			scal <= SCALE_RESET + 6'(k);
			tui <= t_adr[k][5:4];
			tsmp <= t_adr[k][3:0];
			repeat (2) @(posedge ref_clk_i);
			#1;
			check_value(16'(tx_user_active_o), 16'h0001);
			check_value(16'(tx_scaled_amp_o), 16'(t_dat[k]) * 16'(scal));
		end
		@(posedge ref_clk_i);
		tsel <= 4'h7;
		repeat (2) @(posedge ref_clk_i);
		#1;
		check_value(16'({tx_user_active_o, tx_scaled_amp_o}), 16'h0000);
		for (k = 0; k < 16; k++) begin
			c = 3'(k);
			reg_write(RX_CTRL_OFS, {4'h0, c[2], 1'b0, c[1:0]});
			rx_src <= k[3] ? ~pat : pat;
			rx_tick(1'b1, 3);
			rx_tick(1'b0, 3);
			check_value(16'({rd_o, rp_o, rn_o}), 16'(rx_exp(c, rx_src)));
		end
		reg_write(RX_CTRL_OFS, 8'h04);
		rx_src <= ~pat;
		rx_tick(1'b1, 3);
		rx_tick(1'b0, 3);
		@(posedge ref_clk_i);
		rx_src <= pat;
		rx_tick(1'b1, 3);
		check_value(16'(rd_o), 16'h0000);
		rx_tick(1'b0, 3);
		check_value(16'(rd_o), 16'h0001);
		reg_write(RX_CTRL_OFS, 8'h07);
		rx_src <= ~pat;
		rx_tick(1'b0, 3);
		check_value(16'({rd_o, rp_o, rn_o}), 16'h0002);
		reg_write(RX_CTRL_OFS, 8'h18);
		rx_tick(1'b1, 3);
		check_value(16'({pd_o, rd_o, rp_o, rn_o}), 16'h000F);
		reg_write(RX_CTRL_OFS, 8'hFF);
		reg_read(RX_CTRL_OFS, 8'h1F);
		check_value(16'(pd_o), 16'h0001);
		for (k = 0; k < 4; k++) begin
			reg_write(RX_EQ_LOS_OFS, {3'b010, los_c[k]});
			reg_read(RX_EQ_LOS_OFS, {3'b010, los_c[k]});
			check_value(16'({eq_o, prog_o, resv_o}), (k < 2) ? 16'h6 : 16'h5);
			if (k < 2) begin
				check_value(16'(clr_o), 16'({los_c[k], 1'b0}));
				check_value(16'(dcl_o), 16'({los_c[k], 1'b0}) + 16'd4);
			end
		end
		reg_write(RX_EQ_LOS_OFS, 8'h0A);
		reg_read(RX_EQ_LOS_OFS, 8'h0A);
		check_value(16'({eq_o, prog_o}), 16'h0000);
		reg_write(RX_EQ_LOS_OFS, 8'hFF);
		reg_read(RX_EQ_LOS_OFS, 8'h5F);
		finish_test();
	end
endmodule
